// ---- odg_pkg.sv ----
// Purpose: Constants for the output driver gain register bank
// Assumes: One clock at 200 MHz, registers reached over the internal control-port strobes
// Notes: Offsets are byte addresses of the serial control port page
//
// Contract
// - Left headphone route bit follows volume bit seven
// - Right headphone route bit follows volume bit seven
// - Left speaker route bit follows volume bit seven
// - Right speaker route bit follows volume bit seven
// - Seven-bit volume codes, reset to all ones
// - Left headphone gain field, 0 to 9 dB
// - Right headphone gain field, same encoding
// - Left headphone unmute bit, reset muted
// - Right headphone unmute bit, reset muted
// - Left speaker unmute bit, reset muted
// - Left speaker gain field selects 6-24 dB
// - Left headphone status high once gains applied
// - Right headphone status high once gains applied
// - Left speaker status high once gains applied
package odg_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] ADDR_LHP_VOL = 8'h24;
  localparam logic [7:0] ADDR_RHP_VOL = 8'h25;
  localparam logic [7:0] ADDR_LSP_VOL = 8'h26;
  localparam logic [7:0] ADDR_RSP_VOL = 8'h27;
  localparam logic [7:0] ADDR_LHP_CTRL = 8'h28;
  localparam logic [7:0] ADDR_RHP_CTRL = 8'h29;
  localparam logic [7:0] ADDR_LSP_CTRL = 8'h2A;

  // ==========================================================
  // Field positions
  localparam int ROUTE_BIT = 7;
  localparam int VOL_MSB = 6;
  localparam int VOL_LSB = 0;
  localparam int HP_GAIN_MSB = 6;
  localparam int SP_GAIN_MSB = 4;
  localparam int GAIN_LSB = 3;
  localparam int UNMUTE_BIT = 2;
  localparam int STATUS_BIT = 0;

  // ==========================================================
  // Widths and reset values
  localparam int VOL_W = 7;
  localparam int GAIN_W = 4;
  localparam int SP_GAIN_W = 2;
  localparam int NUM_VOL = 4;
  localparam int NUM_DRV = 3;
  localparam logic [7:0] VOL_RESET = 8'h7F;
  localparam logic [7:0] HP_CTRL_RESET = 8'h02;
  localparam logic [7:0] SP_CTRL_RESET = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;

  // ==========================================================
  // Ramp timing
  localparam int CLK_PERIOD_PS = 5000;
  localparam int RAMP_STEP_NS = 1000;
  localparam int RAMP_STEP_CYCLES = (RAMP_STEP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

endpackage

// ---- odg_ramp.sv ----
// Purpose: Steps one driver's applied volume and gain toward the programmed codes
// Assumes: Targets come from registers on the same clock
// Notes: One code step per step period; done is high when both match
`timescale 1ns/1ps

module odg_ramp
  import odg_pkg::*;
#(
  parameter int STEP_CYCLES = RAMP_STEP_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Programmed codes
  input wire logic [VOL_W-1:0] vol_target,
  input wire logic [GAIN_W-1:0] gain_target,
  // Applied codes
  output logic [VOL_W-1:0] vol_applied,
  output logic [GAIN_W-1:0] gain_applied,
  output logic done
);

  localparam int CW = $clog2(STEP_CYCLES + 1);
  localparam logic [CW-1:0] TICK_LAST = CW'(STEP_CYCLES - 1);

  logic [CW-1:0] tick_reg;
  logic tick;

  // ==========================================================
  // Step timer, runs only while something is pending
  assign tick = (tick_reg == TICK_LAST);
  assign done = (vol_applied == vol_target) && (gain_applied == gain_target);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tick_reg <= '0;
    end else if (done || tick) begin
      tick_reg <= '0;
    end else begin
      tick_reg <= tick_reg + CW'(1);
    end
  end

  // ==========================================================
  // Volume stepping
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      vol_applied <= VOL_RESET[VOL_W-1:0];
    end else if (tick && vol_applied < vol_target) begin
      vol_applied <= vol_applied + VOL_W'(1);
    end else if (tick && vol_applied > vol_target) begin
      vol_applied <= vol_applied - VOL_W'(1);
    end
  end

  // ==========================================================
  // Gain stepping
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      gain_applied <= '0;
    end else if (tick && gain_applied < gain_target) begin
      gain_applied <= gain_applied + GAIN_W'(1);
    end else if (tick && gain_applied > gain_target) begin
      gain_applied <= gain_applied - GAIN_W'(1);
    end
  end

endmodule

// ---- odg_regs.sv ----
// Purpose: Output driver volume, gain and mute register bank
// Assumes: Control-port strobes are synchronous to clk
// Notes: Read data is registered, one cycle after the read strobe
`timescale 1ns/1ps

module odg_regs
  import odg_pkg::*;
#(
  parameter int STEP_CYCLES = RAMP_STEP_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,

  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,

  // Headphone path
  output logic lhp_route,
  output logic rhp_route,
  output logic [VOL_W-1:0] lhp_vol,
  output logic [VOL_W-1:0] rhp_vol,
  output logic [GAIN_W-1:0] lhp_gain,
  output logic [GAIN_W-1:0] rhp_gain,
  output logic lhp_unmute,
  output logic rhp_unmute,

  // Speaker path
  output logic lsp_route,
  output logic rsp_route,
  output logic [VOL_W-1:0] lsp_vol,
  output logic [VOL_W-1:0] rsp_vol,
  output logic [SP_GAIN_W-1:0] lsp_gain,
  output logic lsp_unmute,

  // Gain-applied status
  output logic lhp_applied,
  output logic rhp_applied,
  output logic lsp_applied
);

  // ==========================================================
  // Storage
  logic [7:0] vol_reg [NUM_VOL];
  logic [7:0] ctrl_reg [NUM_DRV];
  logic [7:0] reg_rdata_next;
  logic [NUM_DRV-1:0] drv_done;
  logic [VOL_W-1:0] drv_vol [NUM_DRV];
  logic [GAIN_W-1:0] drv_gain_tgt [NUM_DRV];
  logic [GAIN_W-1:0] drv_gain [NUM_DRV];
  logic [7:0] vol_addr [NUM_VOL];
  logic [7:0] ctrl_addr [NUM_DRV];

  assign vol_addr[0] = ADDR_LHP_VOL;
  assign vol_addr[1] = ADDR_RHP_VOL;
  assign vol_addr[2] = ADDR_LSP_VOL;
  assign vol_addr[3] = ADDR_RSP_VOL;
  assign ctrl_addr[0] = ADDR_LHP_CTRL;
  assign ctrl_addr[1] = ADDR_RHP_CTRL;
  assign ctrl_addr[2] = ADDR_LSP_CTRL;

  // ==========================================================
  // Volume registers
  genvar gv;
  generate
    for (gv = 0; gv < NUM_VOL; gv++) begin : g_vol
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          vol_reg[gv] <= VOL_RESET;
        end else if (reg_wr && reg_addr == vol_addr[gv]) begin
          vol_reg[gv] <= reg_wdata;
        end
      end
    end
  endgenerate

  // ==========================================================
  // Driver control registers
  // Status bit is not stored; reserved bits keep what is written
  genvar gd;
  generate
    for (gd = 0; gd < NUM_DRV; gd++) begin : g_ctrl
      // Last driver is the speaker, the rest are headphones
      localparam logic [7:0] CTRL_RST = (gd == NUM_DRV - 1) ? SP_CTRL_RESET : HP_CTRL_RESET;
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          ctrl_reg[gd] <= CTRL_RST;
        end else if (reg_wr && reg_addr == ctrl_addr[gd]) begin
          ctrl_reg[gd] <= {reg_wdata[7:1], 1'b0};
        end
      end
    end
  endgenerate

  // ==========================================================
  // Gain targets per driver
  assign drv_gain_tgt[0] = ctrl_reg[0][HP_GAIN_MSB:GAIN_LSB];
  assign drv_gain_tgt[1] = ctrl_reg[1][HP_GAIN_MSB:GAIN_LSB];
  assign drv_gain_tgt[2] = {{(GAIN_W-SP_GAIN_W){1'b0}}, ctrl_reg[2][SP_GAIN_MSB:GAIN_LSB]};

  // ==========================================================
  // Ramp engines, one per driver with status
  genvar gr;
  generate
    for (gr = 0; gr < NUM_DRV; gr++) begin : g_ramp
      odg_ramp #(
        .STEP_CYCLES(STEP_CYCLES)
      ) u_ramp (
        .clk(clk),
        .nrst(nrst),
        .vol_target(vol_reg[gr][VOL_MSB:VOL_LSB]),
        .gain_target(drv_gain_tgt[gr]),
        .vol_applied(drv_vol[gr]),
        .gain_applied(drv_gain[gr]),
        .done(drv_done[gr])
      );
    end
  endgenerate

  // ==========================================================
  // Route and mute outputs
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lhp_route <= 1'b0;
      rhp_route <= 1'b0;
      lsp_route <= 1'b0;
      rsp_route <= 1'b0;
    end else begin
      lhp_route <= vol_reg[0][ROUTE_BIT];
      rhp_route <= vol_reg[1][ROUTE_BIT];
      lsp_route <= vol_reg[2][ROUTE_BIT];
      rsp_route <= vol_reg[3][ROUTE_BIT];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lhp_unmute <= 1'b0;
      rhp_unmute <= 1'b0;
      lsp_unmute <= 1'b0;
    end else begin
      lhp_unmute <= ctrl_reg[0][UNMUTE_BIT];
      rhp_unmute <= ctrl_reg[1][UNMUTE_BIT];
      lsp_unmute <= ctrl_reg[2][UNMUTE_BIT];
    end
  end

  // ==========================================================
  // Applied volume and gain outputs; right speaker volume is taken straight from its register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lhp_vol <= VOL_RESET[VOL_W-1:0];
      rhp_vol <= VOL_RESET[VOL_W-1:0];
      lsp_vol <= VOL_RESET[VOL_W-1:0];
      rsp_vol <= VOL_RESET[VOL_W-1:0];
      lhp_gain <= '0;
      rhp_gain <= '0;
      lsp_gain <= '0;
    end else begin
      lhp_vol <= drv_vol[0];
      rhp_vol <= drv_vol[1];
      lsp_vol <= drv_vol[2];
      rsp_vol <= vol_reg[3][VOL_MSB:VOL_LSB];
      lhp_gain <= drv_gain[0];
      rhp_gain <= drv_gain[1];
      lsp_gain <= drv_gain[2][SP_GAIN_W-1:0];
    end
  end

  // ==========================================================
  // Gain-applied status, low while a ramp is pending
  // Also waits for the output registers to catch up with the ramp
  assign lhp_applied = drv_done[0] && (lhp_vol == drv_vol[0]) && (lhp_gain == drv_gain[0]);
  assign rhp_applied = drv_done[1] && (rhp_vol == drv_vol[1]) && (rhp_gain == drv_gain[1]);
  assign lsp_applied = drv_done[2] && (lsp_vol == drv_vol[2]) && (lsp_gain == drv_gain[2][SP_GAIN_W-1:0]);

  // ==========================================================
  // Read path
  always_comb begin
    reg_rdata_next = READ_ZERO;
    unique case (reg_addr)
      ADDR_LHP_VOL: reg_rdata_next = vol_reg[0];
      ADDR_RHP_VOL: reg_rdata_next = vol_reg[1];
      ADDR_LSP_VOL: reg_rdata_next = vol_reg[2];
      ADDR_RSP_VOL: reg_rdata_next = vol_reg[3];
      ADDR_LHP_CTRL: begin
        reg_rdata_next = ctrl_reg[0];
        reg_rdata_next[STATUS_BIT] = lhp_applied;
      end
      ADDR_RHP_CTRL: begin
        reg_rdata_next = ctrl_reg[1];
        reg_rdata_next[STATUS_BIT] = rhp_applied;
      end
      ADDR_LSP_CTRL: begin
        reg_rdata_next = ctrl_reg[2];
        reg_rdata_next[STATUS_BIT] = lsp_applied;
      end
      default: reg_rdata_next = READ_ZERO;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= READ_ZERO;
    end else if (reg_rd) begin
      reg_rdata <= reg_rdata_next;
    end
  end

endmodule

// ---- odg_regs_assertions.sv ----
// Purpose: Port-level checks of the output driver gain register bank
// Assumes: Single clock, nrst async active low
// Notes: Bound to odg_regs
`timescale 1ns/1ps

module odg_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // Driver outputs
  input wire logic lhp_route,
  input wire logic rsp_route,
  input wire logic [6:0] lhp_vol,
  input wire logic [6:0] rsp_vol,
  input wire logic [3:0] lhp_gain,
  input wire logic [1:0] lsp_gain,
  input wire logic lhp_unmute,
  input wire logic lsp_unmute,
  input wire logic lhp_applied,
  input wire logic lsp_applied
);
  // ==========================================================
  // Assertions
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  a_lhp_route_follow: assert property (reg_wr && reg_addr == 8'h24 |=> ##1
    lhp_route == $past(reg_wdata[7], 2)) else $error("left headphone route wrong");
  a_rsp_vol_follow: assert property (reg_wr && reg_addr == 8'h27 |=> ##1
    {rsp_route, rsp_vol} == $past(reg_wdata, 2)) else $error("right speaker volume wrong");
  a_lhp_mute_follow: assert property (reg_wr && reg_addr == 8'h28 |=> ##1
    lhp_unmute == $past(reg_wdata[2], 2)) else $error("left headphone mute wrong");
  a_lsp_mute_follow: assert property (reg_wr && reg_addr == 8'h2A |=> ##1
    lsp_unmute == $past(reg_wdata[2], 2)) else $error("left speaker mute wrong");
  a_status_drop_write: assert property (reg_wr && reg_addr == 8'h28 && lhp_applied
    && reg_wdata[6:3] != lhp_gain |=> !lhp_applied) else $error("status not cleared");
  a_lhp_status_read: assert property (reg_rd && reg_addr == 8'h28 |=>
    reg_rdata[0] == $past(lhp_applied)) else $error("left headphone status read wrong");
  a_lsp_status_read: assert property (reg_rd && reg_addr == 8'h2A |=>
    reg_rdata[0] == $past(lsp_applied)) else $error("left speaker status read wrong");
  a_hp_gain_step: assert property ($changed(lhp_gain) |-> lhp_gain - $past(lhp_gain) == 4'h1
    || $past(lhp_gain) - lhp_gain == 4'h1) else $error("headphone gain jumped");
  a_sp_gain_step: assert property ($changed(lsp_gain) |-> lsp_gain - $past(lsp_gain) == 2'h1
    || $past(lsp_gain) - lsp_gain == 2'h1) else $error("speaker gain jumped");
  a_applied_hold_still: assert property (lhp_applied |=> $stable(lhp_gain)
    && $stable(lhp_vol)) else $error("applied codes moved while settled");
  // ==========================================================
  // Covers
  cover property (reg_wr && reg_addr == 8'h28);
  cover property ($rose(lhp_applied));
  cover property ($rose(lsp_applied));
endmodule

bind odg_regs odg_chk odg_chk_inst (.*);

// ---- odg_regs_tb.sv ----
// Purpose: Self-checking bench for the output driver gain register bank
// Assumes: STEP_CYCLES set to 4 to keep ramps short
// Notes: Reads are queued and compared by a monitor
`timescale 1ns/1ps

module odg_regs_tb;
  import odg_pkg::*;
  logic clk = 0, nrst = 0, reg_wr = 0, reg_rd = 0, pend = 0;
  logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata, d;
  logic lhp_route, rhp_route, lsp_route, rsp_route, lhp_unmute, rhp_unmute, lsp_unmute;
  logic lhp_applied, rhp_applied, lsp_applied;
  logic [6:0] lhp_vol, rhp_vol, lsp_vol, rsp_vol;
  logic [3:0] lhp_gain, rhp_gain, rt;
  logic [1:0] lsp_gain;
  logic [7:0] q[$];
  int errors = 0, checks = 0, seed = 52, n;
  assign rt = {rsp_route, lsp_route, rhp_route, lhp_route};
  always #2.5 clk = ~clk;
  odg_regs #(.STEP_CYCLES(4)) odg_regs_inst (.*);

  // ==========================================================
  // Checking
  task chk(input logic [7:0] s, input logic [7:0] e);
    checks++;
    if (s !== e) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  always @(posedge clk) begin
    if (pend)
      chk(reg_rdata, q.pop_front());
    pend <= reg_rd;
  end
  task test_done;
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #200000;
    errors++;
    test_done;
  end

  // ==========================================================
  // Register access
  task acc(input logic w, input logic [7:0] a, input logic [7:0] dt);
    @(posedge clk);
    #1;
    reg_wr = w;
    reg_rd = !w;
    reg_addr = a;
    reg_wdata = dt;
    if (!w)
      q.push_back(dt);
    @(posedge clk);
    #1;
    reg_wr = 0;
    reg_rd = 0;
  endtask
  task settle;
    n = 0;
    while (!(lhp_applied && rhp_applied && lsp_applied) && n < 2000) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 2000)
      errors++;
  endtask
  task ctl(input logic [7:0] a, input logic [3:0] g);
    d = (a == ADDR_LSP_CTRL) ? {3'h0, g[1:0], g[0], 2'h1} : {1'h0, g, g[0], 2'h3};
    acc(1, a, d);
    acc(0, a, d & 8'hFE);
    settle;
    acc(0, a, d);
    @(posedge clk);
    #1;
    case (a)
      ADDR_LHP_CTRL: chk({lhp_gain, lhp_unmute}, {g, g[0]});
      ADDR_RHP_CTRL: chk({rhp_gain, rhp_unmute}, {g, g[0]});
      default: chk({lsp_gain, lsp_unmute}, {g[1:0], g[0]});
    endcase
  endtask

  // ==========================================================
  // Tests
  initial begin
    repeat (10) @(posedge clk);
    #1;
    nrst = 1;
    chk({rt, lhp_unmute, rhp_unmute, lsp_unmute}, 8'h00);
    chk(lhp_vol & rhp_vol & lsp_vol & rsp_vol, 8'h7F);
    for (int a = 8'h24; a <= 8'h2B; a++)
      acc(0, a[7:0], a < 8'h28 ? VOL_RESET : a == 8'h2A ? 8'h01 : a == 8'h2B ? READ_ZERO : 8'h03);
    $display("reset test done");
    for (int a = 8'h24; a <= 8'h27; a++) begin
      d = $random(seed);
      acc(1, a[7:0], d);
      acc(0, a[7:0], d);
      @(posedge clk);
      #1;
      chk(rt[a - 36], d[7]);
      settle;
      chk(a == 8'h24 ? lhp_vol : a == 8'h25 ? rhp_vol : a == 8'h26 ? lsp_vol : rsp_vol, d[6:0]);
    end
    chk(rsp_vol, d[6:0]);
    $display("volume test done");
    for (int g = 1; g <= 10; g++) begin
      ctl(ADDR_LHP_CTRL, 4'(g % 10));
      ctl(ADDR_RHP_CTRL, 4'(g % 10));
    end
    for (int g = 1; g <= 4; g++)
      ctl(ADDR_LSP_CTRL, 4'(g % 4));
    $display("gain test done");
    test_done;
  end
endmodule
